// ---- rtl/har_pkg.sv ----
// Purpose: constants and types shared by the hub address router
// Assumes: 32-bit register words, byte addresses on the register port
// Notes:   legacy location tables are plain defaults
package har_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_FW     = 8'h04;
   localparam logic [7:0] OFS_PM     = 8'h08;
   localparam logic [7:0] OFS_SMB    = 8'h0c;
   localparam logic [7:0] OFS_TCO    = 8'h10;
   localparam logic [7:0] OFS_LEGACY = 8'h14;
   localparam logic [7:0] OFS_SATA   = 8'h18;
   localparam logic [7:0] OFS_LAN    = 8'h1c;
   localparam logic [7:0] OFS_PEER   = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_PORT0  = 8'h40;
   // writable masks, reserved bits read zero
   localparam logic [31:0] MASK_CTRL   = 32'h0303_ffff;
   localparam logic [31:0] MASK_FW     = 32'h0000_7fff;
   localparam logic [31:0] MASK_LEGACY = 32'h000f_ffff;
   localparam logic [31:0] MASK_PEER   = 32'h0fff_0fff;
   localparam logic [31:0] MASK_PORT   = 32'h0001_ffff;
   localparam logic [31:0] MASK_LAN    = 32'hfffe_0001;
   // reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_FW   = 32'h0000_0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // control bit positions
   localparam int CTRL_ALIAS = 0;
   localparam int CTRL_PATCH = 1;
   localparam int CTRL_INTC  = 2;
   localparam int CTRL_PM    = 3;
   localparam int CTRL_SMB   = 4;
   localparam int CTRL_TCO   = 5;
   localparam int CTRL_SATA  = 6;
   localparam int CTRL_ISEL  = 8;
   localparam int CTRL_TSEL  = 24;
   localparam int PORT_EN    = 16;
   localparam int FW_ESEG    = 6;
   localparam int FW_FSEG    = 7;
   localparam int FW_HI0     = 8;
   // fixed I/O ports
   localparam logic [15:0] IO_NMI  = 16'h0061;
   localparam logic [15:0] IO_AL1  = 16'h0063;
   localparam logic [15:0] IO_AL2  = 16'h0065;
   localparam logic [15:0] IO_AL3  = 16'h0067;
   localparam logic [15:0] IO_POST = 16'h0080;
   // selectable 8-byte legacy locations
   localparam logic [15:0] PAR_LOC [3] = '{16'h0378, 16'h0278, 16'h03bc};
   localparam logic [15:0] FDC_LOC [2] = '{16'h03f0, 16'h0370};
   localparam logic [15:0] SER_LOC [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
                                           16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
   // memory windows
   localparam logic [15:0] SEG_E     = 16'h000e;
   localparam logic [15:0] SEG_F     = 16'h000f;
   localparam logic [11:0] INTC_TOP  = 12'hfec;
   localparam logic [11:0] INTC_LAST = 12'h040;
   localparam logic [15:0] TMR_TOP   = 16'hfed0;
   localparam logic [31:0] FAB_LO    = 32'hfed4_c000;
   localparam logic [31:0] FAB_HI    = 32'hfed4_ffff;
   localparam logic [11:0] PATCH_TOP = 12'hfef;
   localparam logic [8:0]  FW_HI_TOP = 9'h1ff;
   localparam logic [8:0]  FW_LO_TOP = 9'h1fe;
   // route targets
   typedef enum logic [3:0] {
      TGT_NONE, TGT_ABORT, TGT_TERM, TGT_CPU_IF, TGT_LEGACY, TGT_FIRMWARE,
      TGT_POWER, TGT_SMBUS, TGT_TIMEOUT, TGT_SATA, TGT_INTC, TGT_ROOT_PORT,
      TGT_TIMER, TGT_FABRIC, TGT_LAN, TGT_UPSTREAM
   } har_target_e;
   localparam har_target_e TGT_PEER = TGT_NONE;
endpackage

// ---- rtl/har_router.sv ----
// Purpose: address decode and routing of hub I/O and memory cycles
// Assumes: one request per cycle, answer registered one cycle later
// Notes:   fixed priority settles overlapping windows
//
// Behaviour
// - alias NMI ports forwarded only when enabled
// - strap one selects eSPI, zero LPC
// - any size starting at 80h decodes alike
// - PM, SMBus, timeout windows placeable anywhere
// - parallel port: 8 bytes, three locations
// - floppy: 8 bytes, two locations
// - three serial ports, eight locations each
// - 16-byte index/data window to SATA
// - unmatched upstream memory cycles master-abort
// - downstream memory claimed except peer ranges
// - downstream memory outside LAN and peer ranges goes upstream
// - E/F segments need enable bits 6/7
// - bits 8-14 enable 512 KB window pairs
// - bits 0-3 enable 1 MB window pairs
// - top 512 KB and alias always firmware
// - interrupt window needs enable, select base
// - root port N gets its enabled window
// - patch region only while enabled
// - timer 1 KB at one of four
// - fabric error range always claimed
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
module har_router
   import har_pkg::*;
#(
   parameter int NUM_PORTS = 24
) (
   input  wire logic        sys_clk_in,        // core clock
   input  wire logic        rst_n_in,          // async reset, low
   input  wire logic        bus_strap_in,      // legacy bus strap pin
   input  wire logic [7:0]  reg_addr_in,       // register byte address
   input  wire logic [31:0] reg_wdata_in,      // register write data
   input  wire logic        reg_wr_in,         // write strobe
   input  wire logic        reg_rd_in,         // read strobe
   output logic      [31:0] reg_rdata_out,     // read data, next cycle
   input  wire logic        req_valid_in,      // cycle present
   input  wire logic        req_io_in,         // 1 I/O, 0 memory
   input  wire logic        req_down_in,       // from downstream master
   input  wire logic [31:0] req_addr_in,       // start address
   output logic             rt_valid_out,      // route valid pulse
   output har_target_e      rt_target_out,     // route target
   output logic      [4:0]  rt_port_out,       // root port index
   output logic             rt_espi_out,       // legacy bus is eSPI
   output logic             rt_abort_out       // master abort
);
   initial begin
      if (NUM_PORTS < 1 || NUM_PORTS > 32) begin
         $error("NUM_PORTS must be 1 to 32");
      end
   end

   logic [31:0] reg_ctrl, reg_fw, reg_pm, reg_smb, reg_tco;
   logic [31:0] reg_legacy, reg_sata, reg_lan, reg_peer;
   logic [31:0] reg_port [NUM_PORTS];
   logic        strap_meta, strap_sync;
   har_target_e next_target;
   logic [4:0]  next_port;
   logic        peer_hit, lan_hit, fw_hit, rp_hit, intc_hit;
   logic [4:0]  rp_idx;
   logic [15:0] ioa;
   logic [31:0] a;
   logic [7:0]  port_ofs;
   logic [4:0]  wr_port;

   assign ioa      = req_addr_in[15:0];
   assign a        = req_addr_in;
   assign port_ofs = reg_addr_in - OFS_PORT0;
   assign wr_port  = port_ofs[6:2];

   // strap pin synchroniser
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= bus_strap_in;
         strap_sync <= strap_meta;
      end
   end

   // software register writes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_ctrl   <= RST_CTRL;
         reg_fw     <= RST_FW;
         reg_pm     <= RST_WORD;
         reg_smb    <= RST_WORD;
         reg_tco    <= RST_WORD;
         reg_legacy <= RST_WORD;
         reg_sata   <= RST_WORD;
         reg_lan    <= RST_WORD;
         reg_peer   <= RST_WORD;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            OFS_CTRL:   reg_ctrl   <= reg_wdata_in & MASK_CTRL;
            OFS_FW:     reg_fw     <= reg_wdata_in & MASK_FW;
            OFS_PM:     reg_pm     <= {16'h0000, reg_wdata_in[15:8], 8'h00};
            OFS_SMB:    reg_smb    <= {16'h0000, reg_wdata_in[15:5], 5'h00};
            OFS_TCO:    reg_tco    <= {16'h0000, reg_wdata_in[15:5], 5'h00};
            OFS_LEGACY: reg_legacy <= reg_wdata_in & MASK_LEGACY;
            OFS_SATA:   reg_sata   <= {16'h0000, reg_wdata_in[15:4], 4'h0};
            OFS_LAN:    reg_lan    <= reg_wdata_in & MASK_LAN;
            OFS_PEER:   reg_peer   <= reg_wdata_in & MASK_PEER;
            default:    ;
         endcase
      end
   end

   // per root port interrupt window registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            reg_port[i] <= RST_WORD;
         end
      end else if (reg_wr_in && reg_addr_in >= OFS_PORT0 && port_ofs[1:0] == 2'b00
                   && 32'(wr_port) < NUM_PORTS && port_ofs[7] == 1'b0) begin
         reg_port[wr_port] <= reg_wdata_in & MASK_PORT;
      end
   end

   // register read data, zero for unmapped addresses
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            OFS_CTRL:   reg_rdata_out <= reg_ctrl;
            OFS_FW:     reg_rdata_out <= reg_fw;
            OFS_PM:     reg_rdata_out <= reg_pm;
            OFS_SMB:    reg_rdata_out <= reg_smb;
            OFS_TCO:    reg_rdata_out <= reg_tco;
            OFS_LEGACY: reg_rdata_out <= reg_legacy;
            OFS_SATA:   reg_rdata_out <= reg_sata;
            OFS_LAN:    reg_rdata_out <= reg_lan;
            OFS_PEER:   reg_rdata_out <= reg_peer;
            OFS_STATUS: reg_rdata_out <= {19'h0, rt_port_out, rt_target_out, 3'h0, strap_sync};
            default: begin
               if (reg_addr_in >= OFS_PORT0 && port_ofs[1:0] == 2'b00
                   && 32'(wr_port) < NUM_PORTS && port_ofs[7] == 1'b0) begin
                  reg_rdata_out <= reg_port[wr_port];
               end else begin
                  reg_rdata_out <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // memory window hits; only the LAN hit is used by both directions
   always_comb begin
      peer_hit = a[31:20] >= reg_peer[11:0] && a[31:20] <= reg_peer[27:16];
      lan_hit  = reg_lan[0] && a[31:17] == reg_lan[31:17];
      intc_hit = reg_ctrl[CTRL_INTC] && a[31:20] == INTC_TOP
                 && a[19:12] == reg_ctrl[CTRL_ISEL +: 8] && a[11:0] <= INTC_LAST;
      fw_hit   = 1'b0;
      if (a[31:23] == FW_HI_TOP) begin
         // 512 KB slots: slot 7 always on, others bits 8-14
         fw_hit = (a[21:19] == 3'h7) || reg_fw[FW_HI0 + 32'(a[21:19])];
      end else if (a[31:23] == FW_LO_TOP) begin
         fw_hit = reg_fw[a[21:20]];
      end else if (a[31:16] == SEG_E) begin
         fw_hit = reg_fw[FW_ESEG];
      end else if (a[31:16] == SEG_F) begin
         fw_hit = reg_fw[FW_FSEG];
      end else if (a[31:20] == PATCH_TOP) begin
         fw_hit = reg_ctrl[CTRL_PATCH];
      end
   end

   // root port windows, lowest port wins
   always_comb begin
      rp_hit = 1'b0;
      rp_idx = 5'h00;
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
         if (reg_port[i][PORT_EN] && a[31:20] == INTC_TOP
             && a[19:12] >= reg_port[i][7:0] && a[19:12] <= reg_port[i][15:8]) begin
            rp_hit = 1'b1;
            rp_idx = 5'(i);
         end
      end
   end

   // route selection in fixed priority order
   always_comb begin
      next_target = TGT_NONE;
      next_port   = 5'h00;
      if (req_io_in) begin
         if (ioa == IO_POST) begin
            next_target = TGT_LEGACY;
         end else if (ioa == IO_NMI) begin
            next_target = TGT_CPU_IF;
         end else if (ioa == IO_AL1 || ioa == IO_AL2 || ioa == IO_AL3) begin
            next_target = reg_ctrl[CTRL_ALIAS] ? TGT_CPU_IF : TGT_TERM;
         end else if (reg_ctrl[CTRL_PM] && ioa[15:8] == reg_pm[15:8]) begin
            next_target = TGT_POWER;
         end else if (reg_ctrl[CTRL_SMB] && ioa[15:5] == reg_smb[15:5]) begin
            next_target = TGT_SMBUS;
         end else if (reg_ctrl[CTRL_TCO] && ioa[15:5] == reg_tco[15:5]) begin
            next_target = TGT_TIMEOUT;
         end else if (reg_ctrl[CTRL_SATA] && ioa[15:4] == reg_sata[15:4]) begin
            next_target = TGT_SATA;
         end else if (reg_legacy[2] && reg_legacy[1:0] != 2'b11
                      && ioa[15:3] == PAR_LOC[reg_legacy[1:0]][15:3]) begin
            next_target = TGT_LEGACY;
         end else if (reg_legacy[5] && ioa[15:3] == FDC_LOC[reg_legacy[4]][15:3]) begin
            next_target = TGT_LEGACY;
         end else if ((reg_legacy[11] && ioa[15:3] == SER_LOC[reg_legacy[10:8]][15:3])
                   || (reg_legacy[15] && ioa[15:3] == SER_LOC[reg_legacy[14:12]][15:3])
                   || (reg_legacy[19] && ioa[15:3] == SER_LOC[reg_legacy[18:16]][15:3])) begin
            next_target = TGT_LEGACY;
         end
      end else if (req_down_in) begin
         if (peer_hit) begin
            next_target = TGT_PEER;
         end else if (lan_hit) begin
            next_target = TGT_LAN;
         end else begin
            next_target = TGT_UPSTREAM;
         end
      end else begin
         if (a >= FAB_LO && a <= FAB_HI) begin
            next_target = TGT_FABRIC;
         end else if (a[31:16] == TMR_TOP && a[15:12] == {2'b00, reg_ctrl[CTRL_TSEL +: 2]}
                      && a[11:10] == 2'b00) begin
            next_target = TGT_TIMER;
         end else if (intc_hit) begin
            next_target = TGT_INTC;
         end else if (rp_hit) begin
            next_target = TGT_ROOT_PORT;
            next_port   = rp_idx;
         end else if (fw_hit) begin
            next_target = TGT_FIRMWARE;
         end else if (lan_hit) begin
            next_target = TGT_LAN;
         end else begin
            next_target = TGT_ABORT;
         end
      end
   end

   // registered route answer
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rt_valid_out  <= 1'b0;
         rt_target_out <= TGT_NONE;
         rt_port_out   <= 5'h00;
         rt_espi_out   <= 1'b0;
         rt_abort_out  <= 1'b0;
      end else begin
         rt_valid_out <= req_valid_in;
         if (req_valid_in) begin
            rt_target_out <= next_target;
            rt_port_out   <= next_port;
            rt_espi_out   <= strap_sync && (next_target == TGT_LEGACY
                             || next_target == TGT_FIRMWARE);
            rt_abort_out  <= next_target == TGT_ABORT;
         end
      end
   end

   // checks on the routing answer
   a_alias_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && req_io_in && ioa == IO_AL2
      |=> rt_target_out == ($past(reg_ctrl[CTRL_ALIAS]) ? TGT_CPU_IF : TGT_TERM))
      else $error("alias port routed against enable");
   a_strap_select: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rt_valid_out && rt_target_out == TGT_LEGACY |-> rt_espi_out == $past(strap_sync))
      else $error("legacy bus select wrong");
   a_post_port: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && req_io_in && ioa == IO_POST |=> rt_valid_out && rt_target_out == TGT_LEGACY)
      else $error("post port not routed to legacy bus");
   a_pm_window: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && req_io_in && reg_ctrl[CTRL_PM] && ioa[15:8] != 8'h00
      && ioa[15:8] == reg_pm[15:8] |=> rt_target_out == TGT_POWER)
      else $error("power block window missed");
   a_abort_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && !req_down_in && a[31:20] == 12'h000
      && a[19:17] != 3'b111 && !lan_hit |=> rt_valid_out && rt_abort_out)
      else $error("unmatched upstream cycle not aborted");
   a_peer_skip: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && req_down_in && peer_hit |=> rt_target_out == TGT_PEER)
      else $error("peer range claimed");
   a_down_upward: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && req_down_in && !peer_hit && !lan_hit
      |=> rt_target_out == TGT_UPSTREAM && !rt_abort_out)
      else $error("downstream cycle not sent upstream");
   a_eseg_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && !req_down_in && a[31:16] == SEG_E && !lan_hit
      |=> rt_target_out == ($past(reg_fw[FW_ESEG]) ? TGT_FIRMWARE : TGT_ABORT))
      else $error("E segment enable ignored");
   a_top_always: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && !req_down_in
      && (a[31:19] == 13'h1fff || a[31:19] == 13'h1ff7) |=> rt_target_out == TGT_FIRMWARE)
      else $error("top firmware region not routed");
   a_intc_claim: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && !req_down_in && intc_hit |=> rt_target_out == TGT_INTC)
      else $error("interrupt window not claimed");
   a_fabric_err: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      req_valid_in && !req_io_in && !req_down_in && a >= FAB_LO && a <= FAB_HI
      |=> rt_target_out == TGT_FABRIC)
      else $error("fabric error range not claimed");
endmodule

// ---- test/har_host_model.sv ----
// Purpose: host link and downstream master model that issues route requests
// Assumes: a request is taken on the rising edge, the router never stalls
// Notes:   idle address lines show the inverse so a stale value never decodes
`timescale 1ns/10ps
module har_host_model (
   input  wire logic        sys_clk_in,     // core clock
   output logic             req_valid_out,  // cycle present
   output logic             req_io_out,     // 1 I/O, 0 memory
   output logic             req_down_out,   // from downstream master
   output logic      [31:0] req_addr_out    // start address
);
   // quiet lines at time zero
   initial begin
      req_valid_out = 1'h0;
      req_io_out    = 1'h0;
      req_down_out  = 1'h0;
      req_addr_out  = 32'h0;
   end
   // present one plain unlocked cycle; calling again keeps cycles back to back
   task automatic put(input logic [1:0] kind, input logic [31:0] addr);
      @(posedge sys_clk_in);
      req_valid_out <= 1'h1;
      req_io_out    <= kind[1];
      req_down_out  <= kind[0];
      req_addr_out  <= addr;
   endtask
   // release the request, address lines flip to the inverse
   task automatic rest();
      @(posedge sys_clk_in);
      req_valid_out <= 1'h0;
      req_addr_out  <= ~req_addr_out;
   endtask
endmodule

// ---- test/hub_address_decode_router_tb_top.sv ----
// Purpose: self-checking bench for the hub address router
// Assumes: route answer one cycle after the request, strap synchronised in 2 edges
// Notes:   table rows run under one setup, awkward cases follow by hand
`timescale 1ns/10ps
module hub_address_decode_router_tb_top import har_pkg::*;;
   typedef struct {
      logic [1:0]  kind;
      logic [31:0] addr;
      har_target_e tgt;
      logic [4:0]  port;
   } har_row_s;
   localparam logic [1:0] UP = 2'h0;
   localparam logic [1:0] DN = 2'h1;
   localparam logic [1:0] IO = 2'h2;
   logic              sys_clk_in, rst_n_in, bus_strap_in, reg_wr_in, reg_rd_in;
   logic        [7:0] reg_addr_in;
   logic       [31:0] reg_wdata_in, reg_rdata_out, req_addr_in;
   logic              req_valid_in, req_io_in, req_down_in;
   logic              rt_valid_out, rt_espi_out, rt_abort_out;
   har_target_e       rt_target_out;
   logic        [4:0] rt_port_out;
   int                fails, tests_run;
   // setup words: address beside data, windows kept off the fixed ports
   logic       [39:0] cfg [12] = '{{OFS_CTRL, 32'h0212127f}, {OFS_FW, 32'hc0},
      {OFS_PM, 32'h4000}, {OFS_SMB, 32'hefa0}, {OFS_TCO, 32'h460}, {OFS_SATA, 32'hf010},
      {OFS_LEGACY, 32'h000af835}, {OFS_LAN, 32'hd0000001}, {OFS_PEER, 32'h080f0800},
      {8'h40, 32'h00013130}, {8'h48, 32'h00013331}, {8'h54, 32'h00004040}};
   // ordinary cases: request beside the route it should get
   har_row_s          rows [51] = '{
      '{IO, 32'h80, TGT_LEGACY, 5'h0}, '{IO, 32'h61, TGT_CPU_IF, 5'h0},
      '{IO, 32'h63, TGT_CPU_IF, 5'h0}, '{IO, 32'h65, TGT_CPU_IF, 5'h0},
      '{IO, 32'h67, TGT_CPU_IF, 5'h0}, '{IO, 32'h4000, TGT_POWER, 5'h0},
      '{IO, 32'h40ff, TGT_POWER, 5'h0}, '{IO, 32'h4100, TGT_NONE, 5'h0},
      '{IO, 32'hefa0, TGT_SMBUS, 5'h0}, '{IO, 32'hefbf, TGT_SMBUS, 5'h0},
      '{IO, 32'h460, TGT_TIMEOUT, 5'h0}, '{IO, 32'h47f, TGT_TIMEOUT, 5'h0},
      '{IO, 32'h480, TGT_NONE, 5'h0}, '{IO, 32'hf010, TGT_SATA, 5'h0},
      '{IO, 32'hf01f, TGT_SATA, 5'h0}, '{IO, 32'hf020, TGT_NONE, 5'h0},
      '{IO, 32'h278, TGT_LEGACY, 5'h0}, '{IO, 32'h27f, TGT_LEGACY, 5'h0},
      '{IO, 32'h378, TGT_NONE, 5'h0}, '{IO, 32'h370, TGT_LEGACY, 5'h0},
      '{IO, 32'h3f0, TGT_NONE, 5'h0}, '{IO, 32'h3f8, TGT_LEGACY, 5'h0},
      '{IO, 32'h3ef, TGT_LEGACY, 5'h0}, '{IO, 32'h220, TGT_LEGACY, 5'h0},
      '{IO, 32'h2f8, TGT_NONE, 5'h0}, '{UP, 32'h000e0000, TGT_FIRMWARE, 5'h0},
      '{UP, 32'h000fffff, TGT_FIRMWARE, 5'h0}, '{UP, 32'h000dffff, TGT_ABORT, 5'h0},
      '{UP, 32'hfec12000, TGT_INTC, 5'h0}, '{UP, 32'hfec12040, TGT_INTC, 5'h0},
      '{UP, 32'hfec12044, TGT_ABORT, 5'h0}, '{UP, 32'hfec31000, TGT_ROOT_PORT, 5'h0},
      '{UP, 32'hfec33000, TGT_ROOT_PORT, 5'h2}, '{UP, 32'hfec40000, TGT_ABORT, 5'h0},
      '{UP, 32'hfef00000, TGT_FIRMWARE, 5'h0}, '{UP, 32'hfeffffff, TGT_FIRMWARE, 5'h0},
      '{UP, 32'hffc80000, TGT_ABORT, 5'h0}, '{UP, 32'hff500000, TGT_ABORT, 5'h0},
      '{UP, 32'hfffc0000, TGT_FIRMWARE, 5'h0}, '{UP, 32'hffb80000, TGT_FIRMWARE, 5'h0},
      '{UP, 32'hfed023ff, TGT_TIMER, 5'h0}, '{UP, 32'hfed00000, TGT_ABORT, 5'h0},
      '{UP, 32'hfed4c000, TGT_FABRIC, 5'h0}, '{UP, 32'hfed4bfff, TGT_ABORT, 5'h0},
      '{UP, 32'hd001ffff, TGT_LAN, 5'h0}, '{UP, 32'hd0020000, TGT_ABORT, 5'h0},
      '{DN, 32'h80000000, TGT_NONE, 5'h0}, '{DN, 32'h80ffffff, TGT_NONE, 5'h0},
      '{DN, 32'h81000000, TGT_UPSTREAM, 5'h0}, '{DN, 32'hd0000000, TGT_LAN, 5'h0},
      '{DN, 32'h7fffffff, TGT_UPSTREAM, 5'h0}};
   // design and far-side model
   har_router #(.NUM_PORTS(24)) uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .bus_strap_in(bus_strap_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .req_valid_in(req_valid_in), .req_io_in(req_io_in), .req_down_in(req_down_in),
      .req_addr_in(req_addr_in), .rt_valid_out(rt_valid_out), .rt_target_out(rt_target_out),
      .rt_port_out(rt_port_out), .rt_espi_out(rt_espi_out), .rt_abort_out(rt_abort_out));
   har_host_model u_host (.sys_clk_in(sys_clk_in), .req_valid_out(req_valid_in),
      .req_io_out(req_io_in), .req_down_out(req_down_in), .req_addr_out(req_addr_in));
   // 100 MHz clock
   always #5 sys_clk_in = ~sys_clk_in;
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // register bus write and read
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_wr_in    <= 1'h1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_in);
      reg_rd_in   <= 1'h1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'h0;
      #1;
      chk(reg_rdata_out, exp);
   endtask
   // check the route answer standing after the taking edge
   task automatic look(input har_target_e t, input logic [4:0] p);
      chk(32'(rt_valid_out), 32'h1);
      chk(32'(rt_target_out), 32'(t));
      chk(32'(rt_abort_out), 32'(t == TGT_ABORT));
      chk(32'(rt_espi_out), 32'(bus_strap_in & (t == TGT_LEGACY || t == TGT_FIRMWARE)));
      if (t == TGT_ROOT_PORT) chk(32'(rt_port_out), 32'(p));
   endtask
   task automatic route(input logic [1:0] k, input logic [31:0] a, input har_target_e t,
                        input logic [4:0] p);
      u_host.put(k, a);
      u_host.rest();
      #1;
      look(t, p);
   endtask
   // hold reset four cycles, route valid and target must sit at rest
   task automatic hold_reset();
      rst_n_in <= 1'h0;
      repeat (4) @(posedge sys_clk_in);
      chk(32'(rt_valid_out), 32'h0);
      chk(32'(rt_target_out), 32'(TGT_NONE));
      rst_n_in <= 1'h1;
   endtask
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #200000;
      fails++;
      conclude();
   end
   // main sequence
   initial begin
      logic [31:0] lo;
      sys_clk_in = 1'h0;
      {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      bus_strap_in = 1'h1;
      fails = 0;
      tests_run = 0;
      hold_reset();
      rd(OFS_CTRL, 32'h0);
      rd(OFS_FW, 32'h0);
      foreach (cfg[i]) wr(cfg[i][39:32], cfg[i][31:0]);
      rd(OFS_LEGACY, 32'h000af835);
      rd(8'h24, 32'h0);
      foreach (rows[i]) route(rows[i].kind, rows[i].addr, rows[i].tgt, rows[i].port);
      rd(OFS_STATUS, 32'h0000_00f1);
      // back to back requests
      u_host.put(IO, 32'h80);
      u_host.put(UP, 32'hfec12000);
      #1;
      look(TGT_LEGACY, 5'h0);
      u_host.rest();
      #1;
      look(TGT_INTC, 5'h0);
      // every window-pair firmware enable bit (0-3, 8-14) on its own
      for (int b = 0; b < 15; b++) begin
         if (b inside {[4:7]}) continue;
         wr(OFS_FW, 32'h1 << b);
         lo = (b >= 8) ? 32'hffc00000 + 32'(b - 8) * 32'h80000 : 32'hff400000 + 32'(b) * 32'h100000;
         route(UP, lo, TGT_FIRMWARE, 5'h0);
         route(UP, lo - 32'h400000, TGT_FIRMWARE, 5'h0);
         route(UP, (b == 8) ? 32'hff400000 : 32'hffc00000, TGT_ABORT, 5'h0);
      end
      // all four timer places
      for (int s = 0; s < 4; s++) begin
         wr(OFS_CTRL, 32'h127f | 32'(s << CTRL_TSEL));
         route(UP, 32'hfed00000 | 32'(s << 12), TGT_TIMER, 5'h0);
         route(UP, 32'hfed003ff | 32'(s << 12), TGT_TIMER, 5'h0);
         route(UP, 32'hfed00400 | 32'(s << 12), TGT_ABORT, 5'h0);
      end
      // alias, patch and interrupt enables cleared
      wr(OFS_CTRL, 32'h1278);
      route(IO, 32'h63, TGT_TERM, 5'h0);
      route(IO, 32'h61, TGT_CPU_IF, 5'h0);
      route(UP, 32'hfef00000, TGT_ABORT, 5'h0);
      route(UP, 32'hfec12000, TGT_ABORT, 5'h0);
      // overlapping windows
      wr(OFS_SATA, 32'h4000);
      route(IO, 32'h4000, TGT_POWER, 5'h0);
      wr(OFS_LAN, 32'hfed40001);
      route(UP, 32'hfed4c000, TGT_FABRIC, 5'h0);
      route(UP, 32'hfed40000, TGT_LAN, 5'h0);
      wr(OFS_LAN, 32'h80000001);
      route(DN, 32'h80000000, TGT_NONE, 5'h0);
      // strap low selects the other legacy bus
      @(posedge sys_clk_in);
      bus_strap_in <= 1'h0;
      repeat (3) @(posedge sys_clk_in);
      route(IO, 32'h80, TGT_LEGACY, 5'h0);
      route(UP, 32'hfffc0000, TGT_FIRMWARE, 5'h0);
      // second reset in mid-run
      @(posedge sys_clk_in);
      hold_reset();
      rd(OFS_FW, 32'h0);
      route(UP, 32'h000e0000, TGT_ABORT, 5'h0);
      route(IO, 32'h63, TGT_TERM, 5'h0);
      conclude();
   end
endmodule
